// [design/t5pg_params.svh]
`ifndef T5PG_PARAMS_SVH
`define T5PG_PARAMS_SVH
`define T5PG_A_PAIR_CTL 8'h3a
`define T5PG_A_CMP6L 8'h40
`define T5PG_A_CMP6H 8'h41
`define T5PG_A_CMP7L 8'h42
`define T5PG_A_CMP7H 8'h43
`define T5PG_A_CAPTURE_THREE_LOW 8'h44
`define T5PG_A_CAPTURE_THREE_HIGH 8'h45
`define T5PG_A_CAPTURE_FOUR_LOW 8'h46
`define T5PG_A_CAPTURE_FOUR_HIGH 8'h47
`define T5PG_A_MODE 8'h48
`define T5PG_A_FFCR 8'h49
`define T5PG_A_WRITE_WIDTH_SEL 8'h4c
`define T5PG_A_PAT1 8'h4d
`define T5PG_A_PATCR 8'h4e
`define T5PG_A_STAT 8'h60
`define T5PG_A_MASK 8'h61
`define T5PG_B_SOFT_CAP 5
`define T5PG_B_DB4 0
`define T5PG_B_DB6 1
`define T5PG_B_TRIG_SEL0 2
`define T5PG_RST_PAIR 4'h0
`define T5PG_RST_MODE 5'h00
`define T5PG_RST_FFEN 4'h0
`define T5PG_RST_PATCR 8'h00
`define T5PG_RST_STAT 6'h00
`define T5PG_RST_CMP 16'hffff
`define T5PG_FLOP_CTL_IDLE 2'h3
`define T5PG_NUM_EV 6
`endif

// [design/t5pg_pkg.sv]
package t5pg_pkg;
  typedef enum logic [1:0]
  {
    T5PG_CAP_OFF = 2'b00,
    T5PG_CAP_PINS_AB = 2'b01,
    T5PG_CAP_PIN_A_BOTH = 2'b10,
    T5PG_CAP_FLOP_ONE = 2'b11
  } t5pg_cap_mode_t;
  typedef enum logic [1:0]
  {
    T5PG_CLK_EXT = 2'b00,
    T5PG_CLK_DIV_A = 2'b01,
    T5PG_CLK_DIV_B = 2'b10,
    T5PG_CLK_DIV_C = 2'b11
  } t5pg_clk_src_t;
  typedef enum logic [1:0]
  {
    T5PG_FLOP_INV = 2'b00,
    T5PG_FLOP_SET = 2'b01,
    T5PG_FLOP_CLR = 2'b10,
    T5PG_FLOP_KEEP = 2'b11
  } t5pg_flop_ctl_t;
  typedef struct packed {
    t5pg_cap_mode_t capture_timing_sel;
    logic clear_en;
    t5pg_clk_src_t clk_sel;
  } t5pg_mode_t;
  typedef struct packed {
    logic write_width_sel;
    logic rotate_dir_sel;
    logic step_size_sel;
    logic trig_input_en;
  } t5pg_pat_ctl_t;
endpackage

// [design/t5pg_timer5_patgen.sv]
`include "t5pg_params.svh"
// Overview of operation
// - Pair control bits 1 and 0 enable double buffering of compare six and four.
// - Trigger select: zero takes timers 0/1, one takes timer four or five.
// - Compare six and seven are 16-bit write-only byte pairs, never read-modify-written.
// - Capture three and four are 16-bit read-only byte pairs loaded from the counter.
// - Writing zero to the soft capture bit latches the counter into capture three.
// - Capture timing field picks none, two pin rises, pin A edges, or flop one edges.
// - Source field picks external input or one of three prescaler ticks.
// - Clear enable lets a match clear the counter; at zero it never clears.
// - Four enables let captures and compare matches invert flop six.
// - Pattern register: write-only output nibble high, readable shift-alternate nibble low.
// - Write-mode bit selects full 8-bit write or 4-bit output-only write.
// - Direction bit selects normal or reverse rotation.
// - Step-mode bit selects 4-bit or 8-bit stepping.
// - Trigger enable lets the selected trigger shift the channel; control resets to zero.
module t5pg_timer5_patgen (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  // Prescaler ticks and neighbouring timer events, same clock
  input wire logic prescale_div_a,
  input wire logic prescale_div_b,
  input wire logic prescale_div_c,
  input wire logic timer_flop_one,
  input wire logic trig_timer01,
  input wire logic trig_timer4,
  // Timer input pins
  input wire logic ext_input_a,
  input wire logic ext_input_b,
  // Block outputs
  output logic [7:0] pattern_out_bit,
  output logic flop_six,
  output logic dbuf_cmp_four_en,
  output logic irq
);
  logic [1:0] ina_sync_r;
  logic [1:0] inb_sync_r;
  logic ina_d_r;
  logic inb_d_r;
  logic flop1_d_r;
  logic [3:0] pair_ctl_r;
  logic [15:0] cmp6_r;
  logic [15:0] cmp6_buf_r;
  logic [15:0] cmp7_r;
  logic [15:0] capture_three_r;
  logic [15:0] capture_four_r;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  t5pg_pkg::t5pg_mode_t mode_r;
  logic [3:0] ffen_r;
  t5pg_pkg::t5pg_pat_ctl_t [1:0] pat_ctl_r;
  logic [5:0] stat_r;
  logic [5:0] mask_r;
  logic [7:0] sa_all;
  logic [1:0] pat_step;
  logic rise_a;
  logic fall_a;
  logic rise_b;
  logic rise_f1;
  logic fall_f1;
  logic tick;
  logic match6;
  logic match7;
  logic soft_wr;
  logic capture_three_ev;
  logic capture_four_ev;
  logic ev_par;
  logic wr_ffcr;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // Pins pass two flops; edges are taken only after the second stage.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ina_sync_r <= 2'h0;
      inb_sync_r <= 2'h0;
      ina_d_r <= 1'b0;
      inb_d_r <= 1'b0;
      flop1_d_r <= 1'b0;
    end
    else
    begin
      ina_sync_r <= {ina_sync_r[0], ext_input_a};
      inb_sync_r <= {inb_sync_r[0], ext_input_b};
      ina_d_r <= ina_sync_r[1];
      inb_d_r <= inb_sync_r[1];
      flop1_d_r <= timer_flop_one;
    end
  end

  assign rise_a = ina_sync_r[1] & ~ina_d_r;
  assign fall_a = ~ina_sync_r[1] & ina_d_r;
  assign rise_b = inb_sync_r[1] & ~inb_d_r;
  assign rise_f1 = timer_flop_one & ~flop1_d_r;
  assign fall_f1 = ~timer_flop_one & flop1_d_r;

  // Control registers.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pair_ctl_r <= `T5PG_RST_PAIR;
      mode_r <= `T5PG_RST_MODE;
      ffen_r <= `T5PG_RST_FFEN;
      pat_ctl_r <= `T5PG_RST_PATCR;
      mask_r <= `T5PG_RST_STAT;
    end
    else if (wr_en)
    begin
      case (addr)
        `T5PG_A_PAIR_CTL: pair_ctl_r <= wdata[3:0];
        `T5PG_A_MODE: mode_r <= wdata[4:0];
        `T5PG_A_FFCR: ffen_r <= wdata[5:2];
        `T5PG_A_PATCR: pat_ctl_r <= wdata;
        `T5PG_A_MASK: mask_r <= wdata[5:0];
        default: ;
      endcase
    end
  end

  assign dbuf_cmp_four_en = pair_ctl_r[`T5PG_B_DB4];

  // Count clock selection.
  always_comb
  begin
    case (mode_r.clk_sel)
      t5pg_pkg::T5PG_CLK_EXT: tick = rise_a;
      t5pg_pkg::T5PG_CLK_DIV_A: tick = prescale_div_a;
      t5pg_pkg::T5PG_CLK_DIV_B: tick = prescale_div_b;
      t5pg_pkg::T5PG_CLK_DIV_C: tick = prescale_div_c;
      default: tick = 1'b0;
    endcase
  end

  // The clear lands on the count after the match, so the matched value is seen for a full count.
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (tick)
    begin
      if (mode_r.clear_en && (cnt_r == cmp7_r))
        cnt_nxt = 16'h0;
      else
        cnt_nxt = 16'(cnt_r + 16'h1);
    end
  end

  assign match6 = tick && (cnt_nxt == cmp6_r);
  assign match7 = tick && (cnt_nxt == cmp7_r);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= 16'h0;
    else
      cnt_r <= cnt_nxt;
  end

  // Compare registers. The buffered copy of compare six moves in on a compare seven match.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmp6_r <= `T5PG_RST_CMP;
      cmp6_buf_r <= `T5PG_RST_CMP;
      cmp7_r <= `T5PG_RST_CMP;
    end
    else
    begin
      if (wr_en && addr == `T5PG_A_CMP6L)
        cmp6_buf_r[7:0] <= wdata;
      if (wr_en && addr == `T5PG_A_CMP6H)
        cmp6_buf_r[15:8] <= wdata;
      if (wr_en && addr == `T5PG_A_CMP7L)
        cmp7_r[7:0] <= wdata;
      if (wr_en && addr == `T5PG_A_CMP7H)
        cmp7_r[15:8] <= wdata;
      if (!pair_ctl_r[`T5PG_B_DB6])
      begin
        if (wr_en && addr == `T5PG_A_CMP6L)
          cmp6_r[7:0] <= wdata;
        if (wr_en && addr == `T5PG_A_CMP6H)
          cmp6_r[15:8] <= wdata;
      end
      else if (match7)
        cmp6_r <= cmp6_buf_r;
    end
  end

  // Capture events.
  assign soft_wr = wr_en && (addr == `T5PG_A_MODE) && !wdata[`T5PG_B_SOFT_CAP];
  always_comb
  begin
    capture_three_ev = soft_wr;
    capture_four_ev = 1'b0;
    case (mode_r.capture_timing_sel)
      t5pg_pkg::T5PG_CAP_PINS_AB:
      begin
        capture_three_ev = soft_wr | rise_a;
        capture_four_ev = rise_b;
      end
      t5pg_pkg::T5PG_CAP_PIN_A_BOTH:
      begin
        capture_three_ev = soft_wr | rise_a;
        capture_four_ev = fall_a;
      end
      t5pg_pkg::T5PG_CAP_FLOP_ONE:
      begin
        capture_three_ev = soft_wr | rise_f1;
        capture_four_ev = fall_f1;
      end
      default: ;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      capture_three_r <= 16'h0;
      capture_four_r <= 16'h0;
    end
    else
    begin
      if (capture_three_ev)
        capture_three_r <= cnt_r;
      if (capture_four_ev)
        capture_four_r <= cnt_r;
    end
  end

  // Flop six. Several enabled events in one cycle invert it once per event.
  assign ev_par = ^({capture_four_ev, capture_three_ev, match7, match6} & ffen_r);
  assign wr_ffcr = wr_en && (addr == `T5PG_A_FFCR);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flop_six <= 1'b0;
    else if (wr_ffcr && wdata[1:0] == t5pg_pkg::T5PG_FLOP_SET)
      flop_six <= 1'b1;
    else if (wr_ffcr && wdata[1:0] == t5pg_pkg::T5PG_FLOP_CLR)
      flop_six <= 1'b0;
    else
      flop_six <= flop_six ^ ev_par ^ (wr_ffcr && wdata[1:0] == t5pg_pkg::T5PG_FLOP_INV);
  end

  // Pattern channels. A write in the same cycle as a step wins and the step is dropped.
  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_pat
      logic [3:0] pout_r;
      logic [3:0] sa_r;
      logic trig_src;
      logic pg_wr;
      assign trig_src = pair_ctl_r[`T5PG_B_TRIG_SEL0 + i] ? ((i == 0) ? trig_timer4 : match7) : trig_timer01;
      assign pat_step[i] = trig_src & pat_ctl_r[i].trig_input_en;
      assign pg_wr = wr_en && (addr == 8'(`T5PG_A_WRITE_WIDTH_SEL + i));
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          pout_r <= 4'h0;
          sa_r <= 4'h0;
        end
        else if (pg_wr)
        begin
          pout_r <= wdata[7:4];
          if (!pat_ctl_r[i].write_width_sel)
            sa_r <= wdata[3:0];
        end
        else if (pat_step[i])
        begin
          if (pat_ctl_r[i].step_size_sel)
          begin
            pout_r <= sa_r;
            sa_r <= pout_r;
          end
          else if (pat_ctl_r[i].rotate_dir_sel)
            pout_r <= {pout_r[0], pout_r[3:1]};
          else
            pout_r <= {pout_r[2:0], pout_r[3]};
        end
      end
      assign pattern_out_bit[4*i +: 4] = pout_r;
      assign sa_all[4*i +: 4] = sa_r;
    end
  endgenerate

  // Interrupt status: set wins over a write-one clear in the same cycle.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      stat_r <= `T5PG_RST_STAT;
    else
      stat_r <= (stat_r & ~((wr_en && addr == `T5PG_A_STAT) ? wdata[5:0] : 6'h0))
                | {pat_step, capture_four_ev, capture_three_ev, match7, match6};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(stat_r & mask_r);
  end

  // Read data. Write-only locations read as zero.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h0;
    else if (rd_en)
    begin
      case (addr)
        `T5PG_A_PAIR_CTL: rdata <= {4'h0, pair_ctl_r};
        `T5PG_A_CAPTURE_THREE_LOW: rdata <= capture_three_r[7:0];
        `T5PG_A_CAPTURE_THREE_HIGH: rdata <= capture_three_r[15:8];
        `T5PG_A_CAPTURE_FOUR_LOW: rdata <= capture_four_r[7:0];
        `T5PG_A_CAPTURE_FOUR_HIGH: rdata <= capture_four_r[15:8];
        `T5PG_A_MODE: rdata <= {2'h0, 1'b1, mode_r};
        `T5PG_A_FFCR: rdata <= {2'h0, ffen_r, `T5PG_FLOP_CTL_IDLE};
        `T5PG_A_WRITE_WIDTH_SEL: rdata <= {4'h0, sa_all[3:0]};
        `T5PG_A_PAT1: rdata <= {4'h0, sa_all[7:4]};
        `T5PG_A_PATCR: rdata <= pat_ctl_r;
        `T5PG_A_STAT: rdata <= {2'h0, stat_r};
        `T5PG_A_MASK: rdata <= {2'h0, mask_r};
        default: rdata <= 8'h0;
      endcase
    end
  end

  a_dbuf_direct: assert property (wr_en && addr == `T5PG_A_CMP6L && !pair_ctl_r[1] |=> cmp6_r[7:0] == $past(wdata))
    else $error("compare six low not written directly");
  a_dbuf_hold: assert property (wr_en && addr == `T5PG_A_CMP6L && pair_ctl_r[1] && !match7 |=> $stable(cmp6_r))
    else $error("buffered compare six changed without match");
  a_trig_sel: assert property (!pair_ctl_r[2] && pat_ctl_r[0].trig_input_en && trig_timer01 |-> pat_step[0])
    else $error("channel zero missed timer 0/1 trigger");
  a_wo_read: assert property (rd_en && addr == `T5PG_A_CMP7H |=> rdata == 8'h0)
    else $error("write-only compare read nonzero");
  a_cap_read: assert property (rd_en && addr == `T5PG_A_CAPTURE_FOUR_HIGH |=> rdata == $past(capture_four_r[15:8]))
    else $error("capture four high read wrong");
  a_soft_cap: assert property (soft_wr |=> capture_three_r == $past(cnt_r))
    else $error("soft capture did not latch counter");
  a_cap_off: assert property (mode_r.capture_timing_sel == t5pg_pkg::T5PG_CAP_OFF |=> $stable(capture_four_r))
    else $error("capture four changed while disabled");
  a_clk_sel: assert property (mode_r.clk_sel == t5pg_pkg::T5PG_CLK_DIV_B && !prescale_div_b |=> $stable(cnt_r))
    else $error("counter moved without selected tick");
  a_no_clear: assert property (tick && !mode_r.clear_en |=> cnt_r == 16'($past(cnt_r) + 16'h1))
    else $error("counter did not run freely");
  a_match_clear: assert property (tick && mode_r.clear_en && cnt_r == cmp7_r |=> cnt_r == 16'h0)
    else $error("counter not cleared after match");
  a_flop_set: assert property (wr_ffcr && wdata[1:0] == 2'h1 |=> flop_six)
    else $error("flop six not set by write");
  a_flop_inv: assert property (!wr_ffcr && ffen_r == 4'h1 && match6 |=> flop_six != $past(flop_six))
    else $error("flop six not inverted on match six");
  a_pat_write: assert property (wr_en && addr == `T5PG_A_WRITE_WIDTH_SEL && pat_ctl_r[0].write_width_sel |=> $stable(sa_all[3:0]))
    else $error("4-bit write changed shift nibble");
  a_pat_out: assert property (wr_en && addr == `T5PG_A_PAT1 |=> pattern_out_bit[7:4] == $past(wdata[7:4]))
    else $error("pattern one output nibble not written");
  a_rot_norm: assert property (pat_step[0] && !(wr_en && addr == `T5PG_A_WRITE_WIDTH_SEL) && pat_ctl_r[0] == 4'h1
    |=> pattern_out_bit[3:0] == {$past(pattern_out_bit[2:0]), $past(pattern_out_bit[3])})
    else $error("normal rotation wrong");
  a_step8: assert property (pat_step[0] && !(wr_en && addr == `T5PG_A_WRITE_WIDTH_SEL) && pat_ctl_r[0].step_size_sel
    |=> pattern_out_bit[3:0] == $past(sa_all[3:0]))
    else $error("8-bit step did not load shift nibble");
  a_trig_off: assert property (!pat_ctl_r[1].trig_input_en |-> !pat_step[1])
    else $error("disabled channel stepped");
endmodule

// [tb/t5pg_pin_model.sv]
module t5pg_pin_model (
  // Requested pin levels
  input wire logic lvl_a,
  input wire logic lvl_b,
  // Timer input pins
  output logic ext_input_a,
  output logic ext_input_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // The pins are asynchronous to the block clock.
  // The skew keeps every pin change away from the edge that the synchronizers sample on.
  initial
  begin
    ext_input_a = 1'b0;
    ext_input_b = 1'b0;
  end
  always @(lvl_a) ext_input_a <= #3 lvl_a;
  always @(lvl_b) ext_input_b <= #3 lvl_b;
endmodule

// [tb/testbench.sv]
`define CHK(w, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %h got %h", w, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [4:0] pls = 5'h00;
  logic tf1 = 1'b0;
  logic lvl_a = 1'b0;
  logic lvl_b = 1'b0;
  logic ext_a;
  logic ext_b;
  logic [7:0] rdata;
  logic [7:0] pattern_out_bit;
  logic [7:0] mode_v;
  logic flop_six;
  logic dbuf_cmp_four_en;
  logic irq;
  logic [15:0] cnt;
  logic [15:0] c1;
  logic [15:0] c2;
  logic [15:0] e3;
  logic [15:0] e4;
  logic [1:0] ops [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
  logic fexp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
  int fails = 0;
  int n_checks = 0;

  always #5 clk = ~clk;

  t5pg_pin_model i_t5pg_pin_model (.lvl_a(lvl_a), .lvl_b(lvl_b), .ext_input_a(ext_a), .ext_input_b(ext_b));

  t5pg_timer5_patgen i_t5pg_timer5_patgen (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .prescale_div_a(pls[0]), .prescale_div_b(pls[1]), .prescale_div_c(pls[2]), .timer_flop_one(tf1),
    .trig_timer01(pls[3]), .trig_timer4(pls[4]), .ext_input_a(ext_a), .ext_input_b(ext_b),
    .pattern_out_bit(pattern_out_bit), .flop_six(flop_six), .dbuf_cmp_four_en(dbuf_cmp_four_en), .irq(irq)
  );

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string w);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    `CHK(w, e, rdata)
  endtask

  task automatic rd16(input logic [7:0] a, input logic [15:0] e, input string w);
    rdc(a, e[7:0], w);
    rdc(a + 8'h01, e[15:8], w);
  endtask

  task automatic pulse(input logic [4:0] p);
    @(posedge clk);
    pls <= p;
    @(posedge clk);
    pls <= 5'h00;
    #1;
  endtask

  // Six cycles cover the two-flop synchronizer and the edge detector with margin.
  task automatic pins(input logic a, input logic f);
    @(posedge clk);
    lvl_a <= a;
    lvl_b <= a;
    tf1 <= f;
    repeat (6) @(posedge clk);
    #1;
  endtask

  task automatic soft_cap();
    wr(8'h48, mode_v & 8'hdf);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic t_reset();
    `CHK("pattern out", 8'h00, pattern_out_bit)
    `CHK("flop six", 1'b0, flop_six)
    rdc(8'h4e, 8'h00, "pattern ctl");
    rdc(8'h48, 8'h20, "mode");
    rdc(8'h49, 8'h03, "flop ctl");
    rdc(8'h40, 8'h00, "compare six");
    rdc(8'h43, 8'h00, "compare seven");
    wr(8'h44, 8'haa);
    rdc(8'h44, 8'h00, "capture three");
    rdc(8'h7f, 8'h00, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_sources();
    cnt = 16'h0000;
    for (int s = 0; s < 4; s++)
    begin
      mode_v = {6'b001000, 2'(s)};
      wr(8'h48, mode_v);
      repeat (3)
      begin
        pulse(5'h07);
        pins(1'b1, 1'b0);
        pins(1'b0, 1'b0);
      end
      cnt = cnt + 16'h0003;
      soft_cap();
      rd16(8'h44, cnt, "capture three");
    end
    wr(8'h48, mode_v);
    pulse(5'h04);
    rd16(8'h44, cnt, "capture three");
    cnt = cnt + 16'h0001;
    rd16(8'h46, 16'h0000, "capture four");
    $display("test sources done");
  endtask

  task automatic t_capture();
    e3 = cnt - 16'h0001;
    e4 = 16'h0000;
    for (int m = 0; m < 4; m++)
    begin
      mode_v = {3'b001, 2'(m), 3'b001};
      wr(8'h48, mode_v);
      pulse(5'h01);
      cnt = cnt + 16'h0001;
      c1 = cnt;
      pins(1'b1, 1'b1);
      pulse(5'h01);
      cnt = cnt + 16'h0001;
      pins(1'b0, 1'b0);
      if (m != 0)
      begin
        e3 = c1;
        e4 = (m == 1) ? c1 : cnt;
      end
      rd16(8'h44, e3, "capture three");
      rd16(8'h46, e4, "capture four");
    end
    $display("test capture done");
  endtask

  task automatic t_clear();
    c1 = cnt + 16'h0001;
    c2 = cnt + 16'h0002;
    wr(8'h40, c1[7:0]);
    wr(8'h41, c1[15:8]);
    wr(8'h42, c2[7:0]);
    wr(8'h43, c2[15:8]);
    wr(8'h60, 8'hff);
    mode_v = 8'h25;
    wr(8'h48, mode_v);
    repeat (4) pulse(5'h01);
    rdc(8'h60, 8'h03, "status");
    soft_cap();
    rd16(8'h44, 16'h0001, "capture three");
    wr(8'h61, 8'h02);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq set", 1'b1, irq)
    wr(8'h60, 8'h02);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq clear", 1'b0, irq)
    mode_v = 8'h21;
    wr(8'h48, mode_v);
    wr(8'h42, 8'h02);
    wr(8'h43, 8'h00);
    repeat (3) pulse(5'h01);
    soft_cap();
    rd16(8'h44, 16'h0004, "capture three");
    $display("test clear done");
  endtask

  task automatic t_flop();
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h49, {6'h00, ops[i]});
      `CHK("flop six", fexp[i], flop_six)
    end
    wr(8'h49, 8'h13);
    rdc(8'h49, 8'h13, "flop ctl");
    soft_cap();
    repeat (2) @(posedge clk);
    #1;
    `CHK("flop six inv", 1'b0, flop_six)
    // A direct write of compare six would match at count 5; the buffered one waits for the compare seven match.
    wr(8'h3a, 8'h02);
    wr(8'h40, 8'h05);
    wr(8'h42, 8'h05);
    wr(8'h49, 8'h07);
    pulse(5'h01);
    `CHK("flop six buffered", 1'b0, flop_six)
    wr(8'h48, 8'h25);
    repeat (6) pulse(5'h01);
    `CHK("flop six match", 1'b1, flop_six)
    wr(8'h48, 8'h21);
    wr(8'h3a, 8'h00);
    wr(8'h49, 8'h03);
    $display("test flop done");
  endtask

  task automatic t_pattern();
    wr(8'h4c, 8'h18);
    `CHK("ch0 out", 4'h1, pattern_out_bit[3:0])
    rdc(8'h4c, 8'h08, "pattern zero");
    pulse(5'h08);
    `CHK("ch0 off", 4'h1, pattern_out_bit[3:0])
    wr(8'h4e, 8'h01);
    pulse(5'h08);
    `CHK("ch0 step", 4'h2, pattern_out_bit[3:0])
    pulse(5'h10);
    `CHK("ch0 sel0", 4'h2, pattern_out_bit[3:0])
    wr(8'h3a, 8'h05);
    `CHK("dbuf four", 1'b1, dbuf_cmp_four_en)
    pulse(5'h08);
    `CHK("ch0 sel1", 4'h2, pattern_out_bit[3:0])
    pulse(5'h10);
    `CHK("ch0 t4", 4'h4, pattern_out_bit[3:0])
    wr(8'h4e, 8'h05);
    pulse(5'h10);
    `CHK("ch0 rev", 4'h2, pattern_out_bit[3:0])
    wr(8'h4e, 8'h03);
    pulse(5'h10);
    `CHK("ch0 swap", 4'h8, pattern_out_bit[3:0])
    rdc(8'h4c, 8'h02, "shift alt");
    wr(8'h4e, 8'h08);
    wr(8'h4c, 8'h5f);
    `CHK("ch0 nib", 4'h5, pattern_out_bit[3:0])
    rdc(8'h4c, 8'h02, "shift alt");
    wr(8'h3a, 8'h00);
    `CHK("dbuf four", 1'b0, dbuf_cmp_four_en)
    wr(8'h4e, 8'h10);
    wr(8'h4d, 8'h30);
    pulse(5'h08);
    `CHK("ch1 step", 8'h65, pattern_out_bit)
    wr(8'h3a, 8'h08);
    pulse(5'h08);
    `CHK("ch1 sel1", 4'h6, pattern_out_bit[7:4])
    wr(8'h42, 8'h06);
    pulse(5'h01);
    `CHK("ch1 t5", 4'hc, pattern_out_bit[7:4])
    $display("test pattern done");
  endtask

  initial
  begin
    #100us;
    fails++;
    $display("ERROR watchdog exp done got hang");
    end_sim();
  end

  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_reset();
    t_sources();
    t_capture();
    t_clear();
    t_flop();
    t_pattern();
    end_sim();
  end
endmodule
